//--- hdl/usq_top.sv
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
module usq_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // serial line
  input  wire logic        rxd,
  output logic             txd,
  // interrupt
  output logic             irq
);
  usq_mem_if #(.AW(usq_pkg::MEM_AW), .DW(usq_pkg::MEM_DW)) mif ();

  usq_mem #(.DEPTH(usq_pkg::MEM_WORDS)) u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .mp      (mif.mem)
  );

  // queue words 86..90 map to slots 0..4, tail word to the last slot
  function automatic logic is_mem(input logic [6:0] idx);
    return (idx == usq_pkg::IDX_TX_TAIL) ||
           ((idx >= usq_pkg::IDX_TX_W0) && (idx <= usq_pkg::IDX_TX_W4));
  endfunction

  function automatic logic [2:0] mem_slot(input logic [6:0] idx);
    logic [6:0] d;
    d = idx - usq_pkg::IDX_TX_W0;
    return (idx == usq_pkg::IDX_TX_TAIL) ? usq_pkg::MEM_TAIL : d[2:0];
  endfunction

  // ---------------- bus slave ----------------
  logic        acc;
  logic [6:0]  a_idx;
  logic        dp_wr_ff,  nxt_dp_wr;
  logic        rd_wait_ff, nxt_rd_wait;
  logic [6:0]  dp_idx_ff, nxt_dp_idx;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic        rd_take;
  logic        wr_take;

  assign acc     = hsel && hready && htrans[1];
  assign a_idx   = haddr[8:2];
  assign rd_take = rd_wait_ff;
  assign wr_take = dp_wr_ff;

  // ---------------- registers ----------------
  logic [3:0]  last_ff, nxt_last;
  logic        nine_ff, nxt_nine;
  logic        tx9_ff,  nxt_tx9;
  logic [15:0] div_ff,  nxt_div;
  logic [3:0]  mask_ff, nxt_mask;
  logic [3:0]  ist_ff,  nxt_ist;
  logic [1:0]  evt_ff,  nxt_evt;
  logic        go;
  logic        ev_rx, ev_tx, ev_frame, ev_glitch;
  // receive status
  logic [7:0]  rbyte_ff, nxt_rbyte;
  logic        r9_ff,    nxt_r9;
  logic        par_ff,   nxt_par;
  logic        stop_ff,  nxt_stop;
  logic        start_ff, nxt_start;
  logic [23:0] rx_status;
  logic [31:0] rd_mux;
  logic        tx_busy;

  assign go = wr_take && (dp_idx_ff == usq_pkg::IDX_CTRL) && hwdata[usq_pkg::CTRL_GO];

  always_comb begin
    rx_status = '0;
    rx_status[7:0] = rbyte_ff;
    rx_status[usq_pkg::RXS_EVT_LSB +: 3] = {r9_ff, evt_ff};
    rx_status[usq_pkg::RXS_PAR_BIT]   = par_ff;
    rx_status[usq_pkg::RXS_START_BIT] = start_ff;
    rx_status[usq_pkg::RXS_STOP_BIT]  = stop_ff;
  end

  always_comb begin
    rd_mux = '0;
    if (is_mem(dp_idx_ff)) begin
      rd_mux[23:0] = mif.rd_a_data;
      if (dp_idx_ff == usq_pkg::IDX_TX_TAIL) begin
        rd_mux[15:0] = '0;
      end
    end else begin
      unique case (dp_idx_ff)
        usq_pkg::IDX_RX_STATUS: rd_mux[23:0] = rx_status;
        usq_pkg::IDX_CTRL: begin
          rd_mux[usq_pkg::CTRL_BUSY] = tx_busy;
          rd_mux[usq_pkg::CTRL_LAST_LSB +: 4] = last_ff;
          rd_mux[usq_pkg::CTRL_NINE] = nine_ff;
          rd_mux[usq_pkg::CTRL_TX9]  = tx9_ff;
          rd_mux[usq_pkg::CTRL_DIV_LSB +: 16] = div_ff;
        end
        usq_pkg::IDX_IRQ_STAT: rd_mux[3:0] = ist_ff;
        usq_pkg::IDX_IRQ_MASK: rd_mux[3:0] = mask_ff;
        default:               rd_mux = '0;
      endcase
    end
  end

  always_comb begin
    nxt_dp_wr   = acc && hwrite;
    nxt_rd_wait = acc && !hwrite;
    nxt_dp_idx  = acc ? a_idx : dp_idx_ff;
    nxt_hrdata  = rd_take ? rd_mux : hrdata_ff;
    nxt_last    = last_ff;
    nxt_nine    = nine_ff;
    nxt_tx9     = tx9_ff;
    nxt_div     = div_ff;
    nxt_mask    = mask_ff;
    if (wr_take && (dp_idx_ff == usq_pkg::IDX_CTRL)) begin
      nxt_last = hwdata[usq_pkg::CTRL_LAST_LSB +: 4];
      nxt_nine = hwdata[usq_pkg::CTRL_NINE];
      nxt_tx9  = hwdata[usq_pkg::CTRL_TX9];
      nxt_div  = (hwdata[31:16] == 16'h0000) ? 16'h0001 : hwdata[31:16];
    end
    if (wr_take && (dp_idx_ff == usq_pkg::IDX_IRQ_MASK)) begin
      nxt_mask = hwdata[3:0];
    end
    // clear on read first, then new events win
    nxt_ist = ist_ff;
    nxt_evt = evt_ff;
    if (rd_take && (dp_idx_ff == usq_pkg::IDX_IRQ_STAT)) begin
      nxt_ist = '0;
    end
    if (rd_take && (dp_idx_ff == usq_pkg::IDX_RX_STATUS)) begin
      nxt_evt = '0;
    end
    if (ev_rx) begin
      nxt_ist[usq_pkg::IRQ_RX] = 1'b1;
      nxt_evt[0] = 1'b1;
    end
    if (ev_tx) begin
      nxt_ist[usq_pkg::IRQ_TX] = 1'b1;
      nxt_evt[1] = 1'b1;
    end
    if (ev_frame) begin
      nxt_ist[usq_pkg::IRQ_FRAME] = 1'b1;
    end
    if (ev_glitch) begin
      nxt_ist[usq_pkg::IRQ_GLITCH] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_ff   <= 1'b0;
      rd_wait_ff <= 1'b0;
      dp_idx_ff  <= '0;
      hrdata_ff  <= '0;
      last_ff    <= usq_pkg::LAST_RST;
      nine_ff    <= 1'b0;
      tx9_ff     <= 1'b0;
      div_ff     <= usq_pkg::DIV_RST;
      mask_ff    <= usq_pkg::IRQ_MASK_RST;
      ist_ff     <= '0;
      evt_ff     <= '0;
    end else begin
      dp_wr_ff   <= nxt_dp_wr;
      rd_wait_ff <= nxt_rd_wait;
      dp_idx_ff  <= nxt_dp_idx;
      hrdata_ff  <= nxt_hrdata;
      last_ff    <= nxt_last;
      nine_ff    <= nxt_nine;
      tx9_ff     <= nxt_tx9;
      div_ff     <= nxt_div;
      mask_ff    <= nxt_mask;
      ist_ff     <= nxt_ist;
      evt_ff     <= nxt_evt;
    end
  end

  // reads cost one wait state because queue words come from a registered memory
  assign hreadyout = !rd_wait_ff;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign irq       = |(ist_ff & mask_ff);

  assign mif.wr_en     = wr_take && is_mem(dp_idx_ff);
  assign mif.wr_addr   = mem_slot(dp_idx_ff);
  assign mif.wr_data   = hwdata[23:0];
  assign mif.rd_a_addr = mem_slot(a_idx);

  // ---------------- oversample divider ----------------
  logic [15:0] div_cnt_ff, nxt_div_cnt;
  logic        tick;
  assign tick = (div_cnt_ff == 16'h0000);
  always_comb begin
    nxt_div_cnt = tick ? (div_ff - 16'h0001) : (div_cnt_ff - 16'h0001);
    // restart on a control write so a new divisor applies at once
    if (wr_take && (dp_idx_ff == usq_pkg::IDX_CTRL)) begin
      nxt_div_cnt = '0;
    end
  end

  // ---------------- transmitter ----------------
  usq_pkg::usq_tx_st_t tx_st_ff, nxt_tx_st;
  logic [3:0]  entry_ff, nxt_entry;
  logic [2:0]  word_ff,  nxt_word;
  logic [1:0]  lane_ff,  nxt_lane;
  logic [10:0] frame_ff, nxt_frame;
  logic [3:0]  tbit_ff,  nxt_tbit;
  logic [3:0]  tcnt_ff,  nxt_tcnt;
  logic        txd_ff,   nxt_txd;
  logic [1:0]  fetch_lane;
  logic [7:0]  fetch_byte;
  logic [3:0]  tx_bits;

  assign tx_busy    = (tx_st_ff != usq_pkg::TX_IDLE);
  assign tx_bits    = nine_ff ? 4'hA : 4'h9;
  // the sixteenth entry lives alone in the tail word
  assign fetch_lane = (entry_ff == usq_pkg::ENTRY_TAIL) ? usq_pkg::TAIL_LANE : lane_ff;
  assign fetch_byte = mif.rd_b_data[fetch_lane * 8 +: 8];
  assign mif.rd_b_addr = (entry_ff == usq_pkg::ENTRY_TAIL) ? usq_pkg::MEM_TAIL : word_ff;

  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_entry = entry_ff;
    nxt_word  = word_ff;
    nxt_lane  = lane_ff;
    nxt_frame = frame_ff;
    nxt_tbit  = tbit_ff;
    nxt_tcnt  = tcnt_ff;
    ev_tx     = 1'b0;
    unique case (tx_st_ff)
      usq_pkg::TX_IDLE: begin
        if (go) begin
          nxt_entry = '0;
          nxt_word  = '0;
          nxt_lane  = '0;
          nxt_tx_st = usq_pkg::TX_FETCH;
        end
      end
      usq_pkg::TX_FETCH: nxt_tx_st = usq_pkg::TX_LOAD;
      usq_pkg::TX_LOAD: begin
        nxt_frame = {1'b1, tx9_ff, fetch_byte, 1'b0};
        if (!nine_ff) begin
          nxt_frame = {1'b1, 1'b1, fetch_byte, 1'b0};
        end
        nxt_tbit  = '0;
        nxt_tcnt  = '0;
        nxt_tx_st = usq_pkg::TX_SEND;
      end
      usq_pkg::TX_SEND: begin
        if (tick) begin
          nxt_tcnt = tcnt_ff + 4'h1;
          if (tcnt_ff == usq_pkg::OVS_LAST) begin
            nxt_frame = {1'b1, frame_ff[10:1]};
            nxt_tbit  = tbit_ff + 4'h1;
            if (tbit_ff == tx_bits) begin
              if (entry_ff == last_ff) begin
                ev_tx     = 1'b1;
                nxt_tx_st = usq_pkg::TX_IDLE;
              end else begin
                nxt_entry = entry_ff + 4'h1;
                nxt_lane  = (lane_ff == 2'h2) ? 2'h0 : lane_ff + 2'h1;
                nxt_word  = (lane_ff == 2'h2) ? word_ff + 3'h1 : word_ff;
                nxt_tx_st = usq_pkg::TX_FETCH;
              end
            end
          end
        end
      end
    endcase
    nxt_txd = (nxt_tx_st == usq_pkg::TX_SEND) ? nxt_frame[0] : 1'b1;
  end

  // ---------------- receiver ----------------
  logic [2:0]  sync_ff, nxt_sync;
  logic        rx_ff,   nxt_rx;
  usq_pkg::usq_rx_st_t rx_st_ff, nxt_rx_st;
  logic [3:0]  rcnt_ff, nxt_rcnt;
  logic [3:0]  rbit_ff, nxt_rbit;
  logic [8:0]  rsh_ff,  nxt_rsh;
  logic        rx_arm_ff, nxt_rx_arm;

  always_comb begin
    // pin change counts once the second and third stages agree
    nxt_sync  = {sync_ff[1:0], rxd};
    nxt_rx    = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : rx_ff;
    nxt_rx_st = rx_st_ff;
    nxt_rcnt  = rcnt_ff;
    nxt_rbit  = rbit_ff;
    nxt_rsh   = rsh_ff;
    nxt_rx_arm = rx_arm_ff;
    nxt_rbyte = rbyte_ff;
    nxt_r9    = r9_ff;
    nxt_par   = par_ff;
    nxt_stop  = stop_ff;
    nxt_start = start_ff;
    ev_rx     = 1'b0;
    ev_frame  = 1'b0;
    ev_glitch = 1'b0;
    unique case (rx_st_ff)
      usq_pkg::RX_IDLE: begin
        // a low stop bit leaves the line low, so wait for idle before hunting
        nxt_rx_arm = rx_arm_ff || rx_ff;
        if (!rx_ff && rx_arm_ff) begin
          nxt_rx_arm = 1'b0;
          nxt_rcnt  = '0;
          nxt_rx_st = usq_pkg::RX_START;
        end
      end
      usq_pkg::RX_START: begin
        if (tick) begin
          nxt_rcnt = rcnt_ff + 4'h1;
          if (rcnt_ff == usq_pkg::OVS_MID) begin
            nxt_start = !rx_ff;
            nxt_rcnt  = '0;
            nxt_rbit  = '0;
            nxt_rx_st = rx_ff ? usq_pkg::RX_IDLE : usq_pkg::RX_DATA;
            ev_glitch = rx_ff;
          end
        end
      end
      usq_pkg::RX_DATA: begin
        if (tick) begin
          nxt_rcnt = rcnt_ff + 4'h1;
          if (rcnt_ff == usq_pkg::OVS_LAST) begin
            nxt_rsh  = {rx_ff, rsh_ff[8:1]};
            nxt_rbit = rbit_ff + 4'h1;
            if (rbit_ff == (nine_ff ? 4'h8 : 4'h7)) begin
              nxt_rx_st = usq_pkg::RX_STOP;
            end
          end
        end
      end
      usq_pkg::RX_STOP: begin
        if (tick) begin
          nxt_rcnt = rcnt_ff + 4'h1;
          if (rcnt_ff == usq_pkg::OVS_LAST) begin
            nxt_rbyte = nine_ff ? rsh_ff[7:0] : rsh_ff[8:1];
            nxt_r9    = nine_ff ? rsh_ff[8] : 1'b0;
            nxt_par   = ^(nine_ff ? rsh_ff[7:0] : rsh_ff[8:1]);
            nxt_stop  = rx_ff;
            ev_rx     = 1'b1;
            ev_frame  = !rx_ff;
            nxt_rx_st = usq_pkg::RX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_ff <= '0;
      tx_st_ff   <= usq_pkg::TX_IDLE;
      entry_ff   <= '0;
      word_ff    <= '0;
      lane_ff    <= '0;
      frame_ff   <= '1;
      tbit_ff    <= '0;
      tcnt_ff    <= '0;
      txd_ff     <= 1'b1;
      sync_ff    <= 3'h7;
      rx_ff      <= 1'b1;
      rx_st_ff   <= usq_pkg::RX_IDLE;
      rcnt_ff    <= '0;
      rbit_ff    <= '0;
      rsh_ff     <= '0;
      rx_arm_ff  <= 1'b1;
      rbyte_ff   <= '0;
      r9_ff      <= 1'b0;
      par_ff     <= 1'b0;
      stop_ff    <= 1'b0;
      start_ff   <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      tx_st_ff   <= nxt_tx_st;
      entry_ff   <= nxt_entry;
      word_ff    <= nxt_word;
      lane_ff    <= nxt_lane;
      frame_ff   <= nxt_frame;
      tbit_ff    <= nxt_tbit;
      tcnt_ff    <= nxt_tcnt;
      txd_ff     <= nxt_txd;
      sync_ff    <= nxt_sync;
      rx_ff      <= nxt_rx;
      rx_st_ff   <= nxt_rx_st;
      rcnt_ff    <= nxt_rcnt;
      rbit_ff    <= nxt_rbit;
      rsh_ff     <= nxt_rsh;
      rx_arm_ff  <= nxt_rx_arm;
      rbyte_ff   <= nxt_rbyte;
      r9_ff      <= nxt_r9;
      par_ff     <= nxt_par;
      stop_ff    <= nxt_stop;
      start_ff   <= nxt_start;
    end
  end

  assign txd = txd_ff;
endmodule

//--- pkg/usq_pkg.sv
// Behaviour
// - read-only receive status word at index 80
// - stop bit detected sets read-only status bit
// - report valid start bit versus line glitch
// - parity flag: odd count of ones reads 1
// - event field: rx event, tx event, ninth bit
// - last received byte in lowest status byte
// - entries 0-2 from word at index 86
// - entries 3-5 from word at index 87
// - entries 6-8 from word at index 88
// - entries 9-11 from word at index 89
// - last entry from tail word high byte
// - entries 12-14 from word at index 90
package usq_pkg;
  // register indices, byte address is index times four
  localparam int unsigned IDX_W         = 7;
  localparam logic [6:0]  IDX_RX_STATUS = 7'h50;
  localparam logic [6:0]  IDX_TX_TAIL   = 7'h54;
  localparam logic [6:0]  IDX_TX_W0     = 7'h56;
  localparam logic [6:0]  IDX_TX_W1     = 7'h57;
  localparam logic [6:0]  IDX_TX_W2     = 7'h58;
  localparam logic [6:0]  IDX_TX_W3     = 7'h59;
  localparam logic [6:0]  IDX_TX_W4     = 7'h5A;
  localparam logic [6:0]  IDX_CTRL      = 7'h60;
  localparam logic [6:0]  IDX_IRQ_STAT  = 7'h61;
  localparam logic [6:0]  IDX_IRQ_MASK  = 7'h62;
  // queue memory
  localparam int unsigned MEM_AW        = 3;
  localparam int unsigned MEM_DW        = 24;
  localparam int unsigned MEM_WORDS     = 6;
  localparam logic [2:0]  MEM_TAIL      = 3'h5;
  localparam logic [1:0]  TAIL_LANE     = 2'h2;
  localparam logic [3:0]  ENTRY_TAIL    = 4'hF;
  // receive status fields
  localparam int unsigned RXS_EVT_LSB   = 8;
  localparam int unsigned RXS_PAR_BIT   = 11;
  localparam int unsigned RXS_START_BIT = 22;
  localparam int unsigned RXS_STOP_BIT  = 23;
  // control fields
  localparam int unsigned CTRL_GO       = 0;
  localparam int unsigned CTRL_BUSY     = 1;
  localparam int unsigned CTRL_LAST_LSB = 4;
  localparam int unsigned CTRL_NINE     = 8;
  localparam int unsigned CTRL_TX9      = 9;
  localparam int unsigned CTRL_DIV_LSB  = 16;
  // interrupt status bits
  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_RX        = 0;
  localparam int unsigned IRQ_TX        = 1;
  localparam int unsigned IRQ_FRAME     = 2;
  localparam int unsigned IRQ_GLITCH    = 3;
  localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;
  // timing
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned BAUD_RST      = 9600;
  localparam int unsigned OVS           = 16;
  localparam logic [3:0]  OVS_LAST      = 4'(OVS - 1);
  localparam logic [3:0]  OVS_MID       = 4'(OVS / 2 - 1);
  localparam logic [15:0] DIV_RST       = 16'(CLK_HZ / (OVS * BAUD_RST));
  localparam logic [3:0]  LAST_RST      = 4'h0;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_FETCH = 4'h2,
    TX_LOAD  = 4'h4,
    TX_SEND  = 4'h8
  } usq_tx_st_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } usq_rx_st_t;
endpackage

//--- pkg/usq_mem_if.sv
`timescale 1ns/100ps
interface usq_mem_if #(
  parameter int unsigned AW = 3,
  parameter int unsigned DW = 24
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_a_addr;
  logic [DW-1:0] rd_a_data;
  logic [AW-1:0] rd_b_addr;
  logic [DW-1:0] rd_b_data;

  modport ctrl (
    output wr_en, wr_addr, wr_data, rd_a_addr, rd_b_addr,
    input  rd_a_data, rd_b_data
  );
  modport mem (
    input  wr_en, wr_addr, wr_data, rd_a_addr, rd_b_addr,
    output rd_a_data, rd_b_data
  );
endinterface

//--- hdl/usq_mem.sv
`timescale 1ns/100ps
module usq_mem #(
  parameter int unsigned DEPTH = 6
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // ports
  usq_mem_if.mem    mp
);
  localparam int unsigned DW = $bits(mp.wr_data);

  logic [DW-1:0] mem_ff [DEPTH];
  logic [DW-1:0] nxt_rd_a;
  logic [DW-1:0] nxt_rd_b;
  logic [DW-1:0] rd_a_ff;
  logic [DW-1:0] rd_b_ff;

  // write-first so a read right after a write sees the new word
  always_comb begin
    nxt_rd_a = mem_ff[mp.rd_a_addr];
    nxt_rd_b = mem_ff[mp.rd_b_addr];
    if (mp.wr_en && (mp.wr_addr == mp.rd_a_addr)) begin
      nxt_rd_a = mp.wr_data;
    end
    if (mp.wr_en && (mp.wr_addr == mp.rd_b_addr)) begin
      nxt_rd_b = mp.wr_data;
    end
  end

  always_ff @(posedge hclk) begin
    if (mp.wr_en) begin
      mem_ff[mp.wr_addr] <= mp.wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_a_ff <= '0;
      rd_b_ff <= '0;
    end else begin
      rd_a_ff <= nxt_rd_a;
      rd_b_ff <= nxt_rd_b;
    end
  end

  assign mp.rd_a_data = rd_a_ff;
  assign mp.rd_b_data = rd_b_ff;
endmodule

//--- sim/usq_chk.sv
`timescale 1ns/100ps
module usq_chk (
  // bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // serial
  input wire logic        txd
);
  logic rd;
  logic wr;
  assign rd = hsel & hready & htrans[1] & ~hwrite;
  assign wr = hsel & hready & htrans[1] & hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_rd_wait;
    rd |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait;
    wr |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_stand;
    $changed(hrdata) |-> !$past(hreadyout);
  endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_unmap;
    rd && haddr[8:2] < 7'h50 |-> ##2 hrdata == 32'h00000000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_tail;
    rd && haddr[8:2] == usq_pkg::IDX_TX_TAIL |-> ##2 hrdata[15:0] == 16'h0000
      && hrdata[31:24] == 8'h00;
  endproperty
  a_tail: assert property (p_tail) else $error("tail unused bits set");
  property p_rxs;
    rd && haddr[8:2] == usq_pkg::IDX_RX_STATUS |-> ##2 hrdata[21:12] == 10'h000
      && hrdata[31:24] == 8'h00;
  endproperty
  a_rxs: assert property (p_rxs) else $error("status spare bits set");
  // any divisor gives at least 16 clocks of start bit; the check requires 8
  property p_start;
    $fell(txd) |-> !txd [*8];
  endproperty
  a_start: assert property (p_start) else $error("start bit too short");
endmodule

bind usq_top usq_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .txd);

//--- sim/usq_peer.sv
`timescale 1ns/100ps
module usq_peer #(
  parameter int BIT = 16
) (
  // line
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic nine,
  output logic      rxd,
  // received character
  output logic       rcv_stb,
  output logic [8:0] rcv_byte
);
  // pulled-up line idles high
  initial begin
    rxd = 1'b1;
    rcv_stb = 1'b0;
    rcv_byte = 9'h000;
  end
  task automatic send(input logic [7:0] d, input logic b9, input logic stp);
    rxd <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= d[i];
      repeat (BIT) @(posedge clk);
    end
    if (nine) begin
      rxd <= b9;
      repeat (BIT) @(posedge clk);
    end
    rxd <= stp;
    repeat (BIT) @(posedge clk);
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  task automatic glitch;
    rxd <= 1'b0;
    repeat (4) @(posedge clk);
    rxd <= 1'b1;
    repeat (2 * BIT) @(posedge clk);
  endtask
  // mid-bit sampling keeps clear of edges
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      rcv_byte[i] = txd;
    end
    if (nine) begin
      repeat (BIT) @(posedge clk);
    end
    repeat (BIT) @(posedge clk);
    rcv_byte[8] = txd;
    rcv_stb = 1'b1;
    @(posedge clk);
    rcv_stb = 1'b0;
  end
endmodule

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        rxd;
  logic        txd;
  logic        irq;
  logic        nine;
  logic        rcv_stb;
  logic [8:0]  rcv_byte;
  logic        rd_ph;
  logic [63:0] rd_q[$];
  logic [8:0]  tx_q[$];
  logic [31:0] w[6];
  logic [7:0]  d;
  logic        stp;
  int          fail_count;
  int          tests_run;

  usq_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rxd, .txd, .irq);
  usq_peer #(.BIT(16)) peer_u (.clk(hclk), .txd, .nine, .rxd, .rcv_stb, .rcv_byte);

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ready sampled just before the edge to avoid racing the slave
  task automatic hold;
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
    end while (!r);
  endtask
  task automatic bus(input logic [6:0] idx, input logic wn, input logic [31:0] dt);
    hsel <= 1'b1;
    haddr <= {23'h000000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wn;
    hold();
    htrans <= 2'h0;
    hwdata <= dt;
    rd_ph = !wn;
    hold();
    rd_ph = 1'b0;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [31:0] dt);
    bus(idx, 1'b1, dt);
  endtask
  task automatic rd(input logic [6:0] idx, input logic [31:0] exp, input logic [31:0] m);
    rd_q.push_back({m, exp & m});
    bus(idx, 1'b0, 32'h00000000);
  endtask
  task automatic irq_is(input logic v);
    @(negedge hclk);
    chk("irq", {31'h00000000, irq}, {31'h00000000, v});
    @(posedge hclk);
  endtask
  task automatic wait_irq;
    for (int n = 0; n < 5000 && irq !== 1'b1; n++) begin
      @(negedge hclk);
    end
    chk("irq raised", {31'h00000000, irq}, 32'h00000001);
    @(posedge hclk);
  endtask
  always @(negedge hclk) begin
    if (rd_ph && hreadyout && rd_q.size() > 0) begin
      chk("hrdata", hrdata & rd_q[0][63:32], rd_q[0][31:0]);
      void'(rd_q.pop_front());
    end
  end
  always @(posedge rcv_stb) begin
    if (tx_q.size() > 0) begin
      chk("tx byte", {23'h000000, rcv_byte}, {23'h000000, tx_q.pop_front()});
    end else begin
      chk("extra tx byte", 32'h00000001, 32'h00000000);
    end
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    nine = 1'b0;
    rd_ph = 1'b0;
    fail_count = 0;
    tests_run = 0;
    void'($urandom(32'h49D78DF9));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(usq_pkg::IDX_CTRL, 32'h01450000, 32'hFFFFFFFF);
    rd(usq_pkg::IDX_IRQ_MASK, 32'h00000000, 32'hFFFFFFFF);
    rd(usq_pkg::IDX_RX_STATUS, 32'h00000000, 32'hFFFFFFFF);
    wr(7'h10, 32'hFFFFFFFF);
    rd(7'h10, 32'h00000000, 32'hFFFFFFFF);
    $display("test map done");
    for (int k = 0; k < 6; k++) begin
      w[k] = $urandom();
      wr(k < 5 ? usq_pkg::IDX_TX_W0 + 7'(k) : usq_pkg::IDX_TX_TAIL, w[k]);
    end
    for (int k = 0; k < 6; k++) begin
      rd(k < 5 ? usq_pkg::IDX_TX_W0 + 7'(k) : usq_pkg::IDX_TX_TAIL,
        w[k] & (k < 5 ? 32'h00FFFFFF : 32'h00FF0000), 32'hFFFFFFFF);
    end
    $display("test queue words done");
    for (int k = 0; k < 15; k++) begin
      tx_q.push_back({1'b1, w[k / 3][8 * (k % 3) +: 8]});
    end
    tx_q.push_back({1'b1, w[5][23:16]});
    wr(usq_pkg::IDX_IRQ_MASK, 32'h00000002);
    wr(usq_pkg::IDX_CTRL, 32'h000100F1);
    wait_irq();
    chk("tx bytes left", 32'(tx_q.size()), 32'h00000000);
    wr(usq_pkg::IDX_IRQ_MASK, 32'h00000000);
    irq_is(1'b0);
    wr(usq_pkg::IDX_IRQ_MASK, 32'h00000002);
    irq_is(1'b1);
    rd(usq_pkg::IDX_IRQ_STAT, 32'h00000002, 32'hFFFFFFFF);
    irq_is(1'b0);
    rd(usq_pkg::IDX_RX_STATUS, 32'h00000200, 32'h00000300);
    rd(usq_pkg::IDX_RX_STATUS, 32'h00000000, 32'h00000300);
    $display("test transmit done");
    wr(usq_pkg::IDX_IRQ_MASK, 32'h0000000D);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom());
      nine = i[0];
      stp = (i != 3);
      wr(usq_pkg::IDX_CTRL, {16'h0001, 7'h00, nine, 8'h00});
      peer_u.send(d, !i[1], stp);
      wait_irq();
      rd(usq_pkg::IDX_RX_STATUS, {8'h00, stp, 1'b1, 10'h000, ^d, !i[1], 1'b0, 1'b1, d},
        {16'hFFFF, 5'h1F, nine, 1'b1, stp, 8'hFF});
      rd(usq_pkg::IDX_IRQ_STAT, {29'h00000000, !stp, 1'b0, stp},
        {29'h00000000, 1'b1, 1'b0, stp});
    end
    $display("test receive done");
    peer_u.glitch();
    wait_irq();
    rd(usq_pkg::IDX_RX_STATUS, 32'h00000000, 32'h00400000);
    rd(usq_pkg::IDX_IRQ_STAT, 32'h00000008, 32'h00000008);
    $display("test glitch done");
    close_out();
  end
endmodule
